/* design/fan_cycle_timer.v */
`timescale 1ns/100ps
`include "thresh_fan_defs.vh"
// Forward/reverse cycle timer; runs while enabled, restarts forward when disabled
module fan_cycle_timer #(
	parameter FWD_CYCLES = `FAN_FWD_CYCLES_DEF,
	parameter REV_CYCLES = `FAN_REV_CYCLES_DEF,
	parameter CNT_W = 37
) (
	input wire i_core_clk,
	input wire i_rst_b,
	input wire i_enable,
	output reg o_reverse
);
	localparam [CNT_W-1:0] FWD_LAST = FWD_CYCLES - 1;
	localparam [CNT_W-1:0] REV_LAST = REV_CYCLES - 1;
	localparam [CNT_W-1:0] CNT_ONE = 1;

	reg [CNT_W-1:0] cnt_q;

	// ****************************************
	// Phase counter
	// ****************************************
	// Stopping restarts the cycle so every start begins forward
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_q <= {CNT_W{1'b0}};
			o_reverse <= 1'b0;
		end else if (!i_enable) begin
			cnt_q <= {CNT_W{1'b0}};
			o_reverse <= 1'b0;
		end else if (!o_reverse && cnt_q == FWD_LAST) begin
			cnt_q <= {CNT_W{1'b0}};
			o_reverse <= 1'b1;
		end else if (o_reverse && cnt_q == REV_LAST) begin
			cnt_q <= {CNT_W{1'b0}};
			o_reverse <= 1'b0;
		end else begin
			cnt_q <= cnt_q + CNT_ONE;
		end
	end
endmodule

/* design/hyst_cmp.v */
`timescale 1ns/100ps
// Signed compare of a temperature against a fixed point; equal holds state
module hyst_cmp #(
	parameter W = 12
) (
	input wire i_core_clk,
	input wire i_rst_b,
	input wire signed [W-1:0] i_value,
	input wire signed [W-1:0] i_thresh,
	output reg o_above
);
	// ****************************************
	// Hold on equality
	// ****************************************
	// Equality keeps the last decision so the fan does not chatter
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_above <= 1'b0;
		end else if (i_value > i_thresh) begin
			o_above <= 1'b1;
		end else if (i_value < i_thresh) begin
			o_above <= 1'b0;
		end
	end
endmodule

/* design/thresh_fan_defs.vh */
`ifndef THRESH_FAN_DEFS_VH
`define THRESH_FAN_DEFS_VH

// ****************************************
// Register map (word index = byte address)
// ****************************************
`define ADDR_W 4
`define REG_ANALOG_LOWER_LIMIT 4'h0
`define REG_ANALOG_UPPER_LIMIT 4'h1
`define REG_HEATSINK_TEMP_LEVEL 4'h2
`define REG_FAN_MODE_SELECT 4'h3
`define REG_HEATSINK_TEMP_READING 4'h4
`define REG_STATUS 4'h5
`define REG_AXIS2_FAN_MODE 4'h6

// ****************************************
// Scaling: volts in 10 mV, temperature in 0.1 degC (signed)
// ****************************************
`define VOLT_W 10
`define TEMP_W 12
`define ANALOG_LOWER_RST 10'h136
`define ANALOG_UPPER_RST 10'h2A8
`define ANALOG_MIN 10'h000
`define ANALOG_MAX 10'h3E8
`define TEMP_LEVEL_RST 12'h2EE
`define TEMP_LEVEL_MIN 12'h000
`define TEMP_LEVEL_MAX 12'h3E8
`define TEMP_READ_MIN 12'hF38
`define TEMP_READ_MAX 12'h4B0
`define FAN_TEMP_THRESH 12'h1A4

// ****************************************
// Fan modes
// ****************************************
`define FAN_MODE_W 2
`define FAN_FWD_RUN 2'h0
`define FAN_FWD_ALWAYS 2'h1
`define FAN_ALT_ALWAYS 2'h2
`define FAN_ALT_RUN 2'h3

// ****************************************
// Timing
// ****************************************
`define CLK_HZ 125000000
`define FAN_FWD_TIME_S 600
`define FAN_REV_TIME_S 200
// 600 s and 200 s at 125 MHz; wider than 32 bits, so sized here
`define FAN_FWD_CYCLES_DEF 37'd75000000000
`define FAN_REV_CYCLES_DEF 37'd25000000000
`define STATUS_W 6

`endif

/* design/threshold_monitor_fan_control.v */
`timescale 1ns/100ps
`include "thresh_fan_defs.vh"

// Overview of operation
// - Window flag set when analog input is above upper or below lower limit.
// - Lower limit accepts 0 V to upper limit; default 3.10 V.
// - Upper limit accepts lower limit to 10 V; default 6.80 V.
// - Temperature flag set when heatsink reaches level; level 0-100 C, default 75.
// - Read-only heatsink temperature reading spans -20.0 to +120.0 C.
// - Fan mode: 0 fwd-run, 1 fwd-always, 2 alt-always, 3 alt-run; default 0.
// - Mode 0: fan forward while running; stopped, runs above 42 C, stops below 42 C, holds its state at exactly 42 C.
// - Mode 1: fan forward continuously, whether or not the axis runs.
// - Mode 2: fan always on, 600 s forward then 200 s reverse, repeating.
// - Mode 3 running: repeat 600 s forward then 200 s reverse.
// - Mode 3 stopped: keep cycling above 42 C, stop below 42 C.
// - Second axis fan mode fixed at 0, read-only; forward while it runs.
module threshold_monitor_fan_control #(
	parameter FAN_FWD_CYCLES = `FAN_FWD_CYCLES_DEF,
	parameter FAN_REV_CYCLES = `FAN_REV_CYCLES_DEF,
	parameter FAN_CNT_W = 37
) (
	input wire i_core_clk,
	input wire i_rst_b,
	input wire [`ADDR_W-1:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [31:0] o_rdata,
	input wire [`VOLT_W-1:0] i_first_analog_input,
	input wire [`TEMP_W-1:0] i_heatsink_temp,
	input wire i_axis1_running,
	input wire i_axis2_running,
	output reg o_analog_window_exceeded,
	output reg o_heatsink_temp_reached,
	output reg o_axis1_fan_on,
	output reg o_axis1_fan_reverse,
	output reg o_axis2_fan_on
);
	// ****************************************
	// Input synchronisers
	// ****************************************
	reg [`VOLT_W-1:0] ain_meta_q;
	reg [`VOLT_W-1:0] ain_q;
	reg [`TEMP_W-1:0] temp_meta_q;
	reg [`TEMP_W-1:0] temp_q;
	reg [1:0] run_meta_q;
	reg [1:0] run_q;

	// Converter words are assumed to update slowly and be held stable
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ain_meta_q <= {`VOLT_W{1'b0}};
			ain_q <= {`VOLT_W{1'b0}};
			temp_meta_q <= {`TEMP_W{1'b0}};
			temp_q <= {`TEMP_W{1'b0}};
			run_meta_q <= 2'h0;
			run_q <= 2'h0;
		end else begin
			ain_meta_q <= i_first_analog_input;
			ain_q <= ain_meta_q;
			temp_meta_q <= i_heatsink_temp;
			temp_q <= temp_meta_q;
			run_meta_q <= {i_axis2_running, i_axis1_running};
			run_q <= run_meta_q;
		end
	end

	// ****************************************
	// Temperature reading clamp
	// ****************************************
	// Reading limited to the documented span so software never sees wild values
	wire signed [`TEMP_W-1:0] temp_s = temp_q;
	wire signed [`TEMP_W-1:0] read_min_s = `TEMP_READ_MIN;
	wire signed [`TEMP_W-1:0] read_max_s = `TEMP_READ_MAX;
	reg [`TEMP_W-1:0] temp_reading_q;

	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			temp_reading_q <= {`TEMP_W{1'b0}};
		end else if (temp_s < read_min_s) begin
			temp_reading_q <= `TEMP_READ_MIN;
		end else if (temp_s > read_max_s) begin
			temp_reading_q <= `TEMP_READ_MAX;
		end else begin
			temp_reading_q <= temp_q;
		end
	end

	// ****************************************
	// Settings registers
	// ****************************************
	reg [`VOLT_W-1:0] analog_lower_limit_q;
	reg [`VOLT_W-1:0] analog_upper_limit_q;
	reg [`TEMP_W-1:0] heatsink_temp_level_q;
	reg [`FAN_MODE_W-1:0] fan_mode_select_q;
	wire [`VOLT_W-1:0] wr_volt = i_wdata[`VOLT_W-1:0];
	wire [`TEMP_W-1:0] wr_temp = i_wdata[`TEMP_W-1:0];
	wire wr_volt_ok = (i_wdata[31:`VOLT_W] == {(32-`VOLT_W){1'b0}});
	wire wr_temp_ok = (i_wdata[31:`TEMP_W] == {(32-`TEMP_W){1'b0}});

	// Out-of-range limit and level writes are dropped whole, keeping lower <= upper at all times; fan mode takes the low 2 bits
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			analog_lower_limit_q <= `ANALOG_LOWER_RST;
			analog_upper_limit_q <= `ANALOG_UPPER_RST;
			heatsink_temp_level_q <= `TEMP_LEVEL_RST;
			fan_mode_select_q <= `FAN_FWD_RUN;
		end else if (i_wr) begin
			case (i_addr)
				`REG_ANALOG_LOWER_LIMIT: begin
					if (wr_volt_ok && wr_volt >= `ANALOG_MIN &&
						wr_volt <= analog_upper_limit_q) begin
						analog_lower_limit_q <= wr_volt;
					end
				end
				`REG_ANALOG_UPPER_LIMIT: begin
					if (wr_volt_ok && wr_volt >= analog_lower_limit_q &&
						wr_volt <= `ANALOG_MAX) begin
						analog_upper_limit_q <= wr_volt;
					end
				end
				`REG_HEATSINK_TEMP_LEVEL: begin
					if (wr_temp_ok && wr_temp >= `TEMP_LEVEL_MIN &&
						wr_temp <= `TEMP_LEVEL_MAX) begin
						heatsink_temp_level_q <= wr_temp;
					end
				end
				`REG_FAN_MODE_SELECT: begin
					fan_mode_select_q <= i_wdata[`FAN_MODE_W-1:0];
				end
				// Axis 2 mode and readings ignore writes
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// Threshold flags
	// ****************************************
	wire signed [`TEMP_W-1:0] level_s = heatsink_temp_level_q;

	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_analog_window_exceeded <= 1'b0;
			o_heatsink_temp_reached <= 1'b0;
		end else begin
			o_analog_window_exceeded <= (ain_q > analog_upper_limit_q) ||
				(ain_q < analog_lower_limit_q);
			o_heatsink_temp_reached <= (temp_s >= level_s);
		end
	end

	// ****************************************
	// Fan control
	// ****************************************
	wire hot;
	wire fan_rev;
	reg axis1_on_d;
	reg cycle_en;

	hyst_cmp #(
		.W(`TEMP_W)
	) u_hot (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_value(temp_s),
		.i_thresh(`FAN_TEMP_THRESH),
		.o_above(hot)
	);

	fan_cycle_timer #(
		.FWD_CYCLES(FAN_FWD_CYCLES),
		.REV_CYCLES(FAN_REV_CYCLES),
		.CNT_W(FAN_CNT_W)
	) u_cycle (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_enable(cycle_en),
		.o_reverse(fan_rev)
	);

	// Mode decode: on/off and whether the alternating cycle runs
	always @* begin
		axis1_on_d = 1'b0;
		cycle_en = 1'b0;
		case (fan_mode_select_q)
			`FAN_FWD_RUN: begin
				axis1_on_d = run_q[0] | hot;
			end
			`FAN_FWD_ALWAYS: begin
				axis1_on_d = 1'b1;
			end
			`FAN_ALT_ALWAYS: begin
				axis1_on_d = 1'b1;
				cycle_en = 1'b1;
			end
			`FAN_ALT_RUN: begin
				axis1_on_d = run_q[0] | hot;
				cycle_en = axis1_on_d;
			end
			default: begin
				axis1_on_d = 1'b0;
			end
		endcase
	end

	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_axis1_fan_on <= 1'b0;
			o_axis1_fan_reverse <= 1'b0;
			o_axis2_fan_on <= 1'b0;
		end else begin
			o_axis1_fan_on <= axis1_on_d;
			o_axis1_fan_reverse <= axis1_on_d & cycle_en & fan_rev;
			o_axis2_fan_on <= run_q[1] | hot;
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	// Unmapped addresses read zero
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rdata <= 32'h0;
		end else if (i_rd) begin
			case (i_addr)
				`REG_ANALOG_LOWER_LIMIT: o_rdata <= {{(32-`VOLT_W){1'b0}}, analog_lower_limit_q};
				`REG_ANALOG_UPPER_LIMIT: o_rdata <= {{(32-`VOLT_W){1'b0}}, analog_upper_limit_q};
				`REG_HEATSINK_TEMP_LEVEL: o_rdata <= {{(32-`TEMP_W){1'b0}}, heatsink_temp_level_q};
				`REG_FAN_MODE_SELECT: o_rdata <= {{(32-`FAN_MODE_W){1'b0}}, fan_mode_select_q};
				`REG_HEATSINK_TEMP_READING: begin
					o_rdata <= {{(32-`TEMP_W){temp_reading_q[`TEMP_W-1]}}, temp_reading_q};
				end
				`REG_STATUS: begin
					o_rdata <= {{(32-`STATUS_W){1'b0}}, o_axis2_fan_on, o_axis1_fan_reverse,
						o_axis1_fan_on, hot, o_heatsink_temp_reached, o_analog_window_exceeded};
				end
				`REG_AXIS2_FAN_MODE: o_rdata <= {{(32-`FAN_MODE_W){1'b0}}, `FAN_FWD_RUN};
				default: o_rdata <= 32'h0;
			endcase
		end else begin
			o_rdata <= 32'h0;
		end
	end
endmodule

/* tb/sensor_front_model.sv */
`timescale 1ns/100ps
// ****
// Converter front end for voltage and heatsink sensor
// ****
module sensor_front_model (
	input wire i_core_clk,
	input wire [9:0] i_volt_set,
	input wire [11:0] i_temp_set,
	output reg [9:0] o_volt = 10'h000,
	output reg [11:0] o_temp = 12'h000
);
	// One conversion per clock; no noise or slew, so edges are exact
	always @(posedge i_core_clk) begin
		o_volt <= i_volt_set;
		o_temp <= i_temp_set;
	end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
	reg i_core_clk = 1'b0;
	reg i_rst_b = 1'b0;
	reg [3:0] i_addr = 4'h0;
	reg [31:0] i_wdata = 32'h0;
	reg i_wr = 1'b0;
	reg i_rd = 1'b0;
	reg [9:0] volt_set = 10'h1F4;
	reg [11:0] temp_set = 12'h0C8;
	reg run1 = 1'b0;
	reg run2 = 1'b0;
	wire [31:0] o_rdata;
	wire [9:0] volt;
	wire [11:0] temp;
	wire win, lvl, fan1, rev1, fan2;
	integer bad_count = 0;
	integer total_checks = 0;
	integer n;
	// 125 MHz core clock
	always #4 i_core_clk = ~i_core_clk;
	sensor_front_model sensor_front_model_inst (.i_core_clk(i_core_clk), .i_volt_set(volt_set),
		.i_temp_set(temp_set), .o_volt(volt), .o_temp(temp));
	// Short fan cycle keeps the run brief
	threshold_monitor_fan_control #(.FAN_FWD_CYCLES(30), .FAN_REV_CYCLES(10), .FAN_CNT_W(37))
		threshold_monitor_fan_control_inst (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_first_analog_input(volt), .i_heatsink_temp(temp), .i_axis1_running(run1),
		.i_axis2_running(run2), .o_analog_window_exceeded(win), .o_heatsink_temp_reached(lvl),
		.o_axis1_fan_on(fan1), .o_axis1_fan_reverse(rev1), .o_axis2_fan_on(fan2));
	// ****
	// Tasks
	// ****
	task close_out;
		begin
			if (bad_count == 0 && total_checks > 0) $display("No errors found");
			else $display("Errors were found");
			$finish;
		end
	endtask
	task chk(input string what, input [31:0] seen, input [31:0] exp);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp) begin
				bad_count = bad_count + 1;
				$display("[ERR] %0s exp %0h seen %0h", what, exp, seen);
			end
		end
	endtask
	task wr(input [3:0] a, input [31:0] d);
		begin
			@(posedge i_core_clk);
			i_wr <= 1'b1;
			i_addr <= a;
			i_wdata <= d;
			@(posedge i_core_clk);
			i_wr <= 1'b0;
		end
	endtask
	// Read data stands only in the cycle after the strobe
	task rd(input [3:0] a, input [31:0] exp);
		begin
			@(posedge i_core_clk);
			i_rd <= 1'b1;
			i_addr <= a;
			@(posedge i_core_clk);
			i_rd <= 1'b0;
			#1 chk("rdata", o_rdata, exp);
		end
	endtask
	// Seven edges cover sensor, sync and hot flag latency
	task step(input [9:0] v, input [11:0] t, input r1, input r2, input [4:0] e);
		begin
			@(posedge i_core_clk);
			volt_set <= v;
			temp_set <= t;
			run1 <= r1;
			run2 <= r2;
			repeat (7) @(posedge i_core_clk);
			#1 chk("outputs", {win, lvl, fan1, rev1, fan2}, {27'h0, e});
		end
	endtask
	task span(input lv, output integer c);
		begin
			c = 0;
			while (rev1 === lv && c < 200) begin
				@(posedge i_core_clk);
				#1 c = c + 1;
			end
		end
	endtask
	// Hang guard, well beyond the sequence length
	initial begin
		repeat (5000) @(posedge i_core_clk);
		bad_count = bad_count + 1;
		close_out;
	end
	// ****
	// Sequence
	// ****
	initial begin
		repeat (8) @(posedge i_core_clk);
		i_rst_b <= 1'b1;
		rd(4'h0, 32'h136);
		rd(4'h1, 32'h2A8);
		rd(4'h2, 32'h2EE);
		rd(4'h3, 32'h0);
		rd(4'hF, 32'h0);
		wr(4'h0, 32'h2BC);
		rd(4'h0, 32'h136);
		wr(4'h1, 32'h12C);
		wr(4'h1, 32'h3E9);
		rd(4'h1, 32'h2A8);
		wr(4'h2, 32'h3E9);
		rd(4'h2, 32'h2EE);
		wr(4'h6, 32'h1);
		rd(4'h6, 32'h0);
		wr(4'h0, 32'h0);
		wr(4'h1, 32'h3E8);
		rd(4'h0, 32'h0);
		rd(4'h1, 32'h3E8);
		wr(4'h0, 32'h136);
		wr(4'h1, 32'h2A8);
		// Window edges and temperature level
		step(10'h1F4, 12'h2ED, 1'b0, 1'b0, 5'h05);
		step(10'h2A9, 12'h2EE, 1'b0, 1'b0, 5'h1D);
		step(10'h2A8, 12'h12C, 1'b0, 1'b0, 5'h00);
		step(10'h135, 12'hED4, 1'b0, 1'b0, 5'h10);
		rd(4'h4, 32'hFFFFFF38);
		step(10'h136, 12'h514, 1'b0, 1'b0, 5'h0D);
		rd(4'h5, 32'h2E);
		rd(4'h4, 32'h4B0);
		// Mode 0 with the 42 degree hold band
		step(10'h1F4, 12'h1A4, 1'b0, 1'b0, 5'h05);
		step(10'h1F4, 12'h19A, 1'b0, 1'b0, 5'h00);
		step(10'h1F4, 12'h1A4, 1'b0, 1'b0, 5'h00);
		rd(4'h4, 32'h1A4);
		step(10'h1F4, 12'h12C, 1'b1, 1'b0, 5'h04);
		step(10'h1F4, 12'h12C, 1'b0, 1'b1, 5'h01);
		wr(4'h3, 32'h1);
		step(10'h1F4, 12'h12C, 1'b0, 1'b0, 5'h04);
		wr(4'h3, 32'h2);
		span(1'b0, n);
		chk("on", fan1, 32'h1);
		span(1'b1, n);
		chk("rev", n, 32'hA);
		span(1'b0, n);
		chk("fwd", n, 32'h1E);
		wr(4'h3, 32'h3);
		step(10'h1F4, 12'h12C, 1'b0, 1'b0, 5'h00);
		step(10'h1F4, 12'h12C, 1'b1, 1'b0, 5'h04);
		span(1'b0, n);
		span(1'b1, n);
		chk("rev", n, 32'hA);
		span(1'b0, n);
		chk("fwd", n, 32'h1E);
		step(10'h1F4, 12'h1AE, 1'b0, 1'b0, 5'h05);
		span(1'b0, n);
		span(1'b1, n);
		chk("rev", n, 32'hA);
		step(10'h1F4, 12'h12C, 1'b0, 1'b0, 5'h00);
		close_out;
	end
endmodule

/* tb/thresh_fan_chk_assertions.sv */
`timescale 1ns/100ps
// ****
// Port checks
// ****
module thresh_fan_chk (
	input wire i_core_clk,
	input wire i_rst_b,
	input wire [3:0] i_addr,
	input wire i_rd,
	input wire [31:0] o_rdata,
	input wire [11:0] i_heatsink_temp,
	input wire i_axis2_running,
	input wire o_analog_window_exceeded,
	input wire o_heatsink_temp_reached,
	input wire o_axis1_fan_on,
	input wire o_axis1_fan_reverse,
	input wire o_axis2_fan_on
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	// Signed view of the sensor word
	wire signed [11:0] tmp = i_heatsink_temp;
	property p_ax2_run; i_axis2_running[*3] |=> o_axis2_fan_on; endproperty
	a_ax2_run: assert property (p_ax2_run) else $error("axis2 fan off");
	property p_rev_on; o_axis1_fan_reverse |-> o_axis1_fan_on; endproperty
	a_rev_on: assert property (p_rev_on) else $error("reverse while off");
	property p_lvl_hi; (tmp >= 1000)[*4] |=> o_heatsink_temp_reached; endproperty
	a_lvl_hi: assert property (p_lvl_hi) else $error("level flag missing");
	property p_lvl_neg; (tmp < 0)[*4] |=> !o_heatsink_temp_reached; endproperty
	a_lvl_neg: assert property (p_lvl_neg) else $error("level flag spurious");
	property p_hot; (tmp > 420)[*4] |=> o_axis2_fan_on; endproperty
	a_hot: assert property (p_hot) else $error("hot fan off");
	property p_cold; (!i_axis2_running && tmp < 420)[*4] |=> !o_axis2_fan_on; endproperty
	a_cold: assert property (p_cold) else $error("cold fan on");
	property p_hold; (!i_axis2_running && tmp == 420)[*6] |=> $stable(o_axis2_fan_on); endproperty
	a_hold: assert property (p_hold) else $error("fan toggled at 42");
	property p_ro; i_rd && i_addr == 4'h6 |=> o_rdata == 32'h0; endproperty
	a_ro: assert property (p_ro) else $error("axis2 mode not 0");
	property p_clamp; i_rd && i_addr == 4'h4 |=> $signed(o_rdata) >= -200
		&& $signed(o_rdata) <= 1200; endproperty
	a_clamp: assert property (p_clamp) else $error("reading out of span");
	c_rev: cover property (o_axis1_fan_reverse);
	c_win: cover property (o_analog_window_exceeded);
	c_lvl: cover property (o_heatsink_temp_reached);
endmodule
bind threshold_monitor_fan_control thresh_fan_chk thresh_fan_chk_inst (.i_core_clk(i_core_clk),
	.i_rst_b(i_rst_b), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_heatsink_temp(i_heatsink_temp), .i_axis2_running(i_axis2_running),
	.o_analog_window_exceeded(o_analog_window_exceeded),
	.o_heatsink_temp_reached(o_heatsink_temp_reached), .o_axis1_fan_on(o_axis1_fan_on),
	.o_axis1_fan_reverse(o_axis1_fan_reverse), .o_axis2_fan_on(o_axis2_fan_on));
